// file: verilog/vme_bridge_consts.svh
/*
 * register offsets, field positions, reset values and timing counts
 * assumes: included by bare name from the design files
 */
`ifndef VME_BRIDGE_CONSTS_SVH
`define VME_BRIDGE_CONSTS_SVH

// register offsets
`define OFF_REQUESTER   8'h03
`define OFF_MASTER      8'h05
`define OFF_SLAVE       8'h07
`define OFF_TIMEOUT     8'h09
`define OFF_ERR_STATUS  8'h15

// requester register fields
`define BIT_WANTS_BUS   7
`define BIT_HOLDS_BUS   6

// master register fields
`define BIT_DELAY_ACK   7
`define BIT_OLDER_CPU   6
`define BIT_MST_POST    5
`define BIT_CACHE_FILL  4
`define BIT_SHORT_ADDR  2
`define BIT_STD_ADDR    1

// slave register fields
`define BIT_SLV_EN      7
`define BIT_SLV_POST    5
`define BIT_SLV_NARROW  0

// timeout register fields
`define LSB_LOCAL_SEL   0
`define LSB_ACCESS_SEL  2
`define LSB_BUS_SEL     4
`define BIT_ARB_EN      6

// error status fields
`define BIT_LOCAL_TO    0

// reset values
`define RST_MASTER      8'h00
`define RST_SLAVE       8'h00
`define RST_TIMEOUT     8'h00

// timing
`define CLK_NS          40
`define T_1K            20'd1024
`define T_2K            20'd2048
`define T_4K            20'd4096
`define ARB_WAIT_CYC    13'd4096
`define ARB_HOLD_NS     90
`define ARB_HOLD_CYC    ((`ARB_HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define ACK_DELAY_CYC   2'd2

// address modifier upper bits
`define AM_SHORT        3'b101
`define AM_STD          3'b111
`define AM_EXT          3'b001

`endif

// file: verilog/vme_bridge_pkg.sv
/*
 * types shared by the bridge configuration and timeout logic
 * assumes: nothing beyond a SystemVerilog compiler
 */
package vme_bridge_pkg;

	// master cycle sequencer
	typedef enum logic [2:0] {
		M_IDLE,
		M_WAIT_BUS,
		M_STROBE,
		M_ACK_DLY,
		M_ACK,
		M_POST,
		M_ABORT
	} mstate_t;

endpackage

// file: verilog/vme_bridge_config_and_timeouts.sv
/*
 * configuration registers, master cycle control and the four watchdog
 * timers of a local bus to VMEbus bridge.
 * assumes: requester supplies bus_held; slave logic supplies slave_busy
 * on clk; every pin input is asynchronous and synchronised here.
 */
// The address-and-strobe port is this design's own decision.
// Operation
// - short address gives AM 101, standard 111
// - function codes copied onto AM2..AM0
// - cache fill makes reads fetch 4 bytes
// - master posting acknowledges writes early
// - posting waits for mastership if slave enabled
// - posted write errors not reported as berr
// - lockup break: berr plus halt unless older
// - abort local cycle while slave accessed
// - delayed ack adds delay after dtack
// - narrow slave bit limits to D08/D16
// - slave posting acknowledges VMEbus writes early
// - slave responds only when enabled
// - arbitration and bus timers need syscon
// - local timer start, stop, expiry effects
// - local timeout select 1K/2K/4K/off
// - access timer start, stop, berr on expiry
// - access timeout select 1K/16K/524290/off
// - bus timer runs on data strobes, BERR
// - bus timeout select 1K/2K/4K/off
// - arbitration timeout drives BBSY 90ns
// - holds bus reflects mastership, wants requests
`timescale 1ns/1ns
`include "vme_bridge_consts.svh"

module vme_bridge_config_and_timeouts #(
	parameter logic [19:0] ACC_MID_CYC  = 20'd16384,
	parameter logic [19:0] ACC_LONG_CYC = 20'd524290
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// local bus pins
	input  wire logic       local_data_strobe_n,
	input  wire logic       local_write,
	input  wire logic [2:0] fc,
	input  wire logic       vme_window_select_in_n,
	input  wire logic       local_int_ack_in_n,
	input  wire logic       short_io_select_in_n,
	input  wire logic       standard_address_select_in_n,
	input  wire logic       system_controller_select_in_n,
	output logic            local_bus_error_out_n,
	output logic            local_halt_out_n,
	output logic      [1:0] local_data_ack_out_n,
	// VMEbus pins
	input  wire logic       dtack_n,
	input  wire logic       berr_in_n,
	input  wire logic [1:0] vme_ds_in_n,
	input  wire logic       bus_grant_n,
	input  wire logic       bbsy_in_n,
	input  wire logic       quad_capable,
	output logic      [5:0] am_out,
	output logic            vme_strobe_out,
	output logic            quad_read_out,
	output logic            berr_out_n,
	output logic            bbsy_out_n,
	// neighbouring blocks on clk
	input  wire logic       bus_held,
	input  wire logic       slave_busy,
	output logic            wants_bus,
	output logic            posted_error,
	output logic            slave_enable,
	output logic            slave_narrow,
	output logic            slave_posting
);

	localparam int NS = 17;

	logic [NS-1:0] s1_q;
	logic [NS-1:0] s2_q;
	logic [7:0]    master_q;
	logic [7:0]    slave_q;
	logic [7:0]    timeout_q;
	logic          wants_q;
	logic          lto_flag_q;
	logic [7:0]    rdata_q;
	logic [12:0]   lcnt_q;
	logic [19:0]   acnt_q;
	logic [12:0]   bcnt_q;
	logic [12:0]   arb_q;
	logic [1:0]    hold_q;
	logic          bbsy_drv_q;
	logic          lto_err_q;
	logic          ato_err_q;
	logic          vberr_q;
	logic [1:0]    dly_q;
	logic          local_berr_q;
	logic          halt_q;
	logic [1:0]    ack_q;
	logic [5:0]    am_q;
	logic          quad_q;
	logic          perr_q;
	vme_bridge_pkg::mstate_t st_q;

	// synchronised pins, active high
	logic ds, wr, vsel, iack, shrt, std24, syscon, dtack, berr;
	logic vds, bg, bbsy, quad;
	logic [2:0] fcs;
	logic lt_run, lt_exp, at_run, at_exp, bt_run, bt_exp, arb_exp;
	logic [19:0] lt_lim, at_lim, bt_lim;
	logic wr_en;

	// limit for the 1K/2K/4K timers, code 3 is off
	function automatic logic [19:0] short_lim(input logic [1:0] s);
		case (s)
			2'b00:   short_lim = `T_1K;
			2'b01:   short_lim = `T_2K;
			default: short_lim = `T_4K;
		endcase
	endfunction

	// two-flop synchroniser for all pin inputs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {~local_data_strobe_n, local_write,
				~vme_window_select_in_n, ~local_int_ack_in_n,
				~short_io_select_in_n,
				~standard_address_select_in_n,
				~system_controller_select_in_n, fc,
				~dtack_n, ~berr_in_n, ~vme_ds_in_n,
				~bus_grant_n, ~bbsy_in_n, quad_capable};
			s2_q <= s1_q;
		end
	end

	assign {ds, wr, vsel, iack, shrt, std24, syscon, fcs, dtack, berr}
		= s2_q[16:5];
	assign vds  = |s2_q[4:3];
	assign bg   = s2_q[2];
	assign bbsy = s2_q[1];
	assign quad = s2_q[0];

	// register writes
	assign wr_en = reg_wr;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			master_q  <= `RST_MASTER;
			slave_q   <= `RST_SLAVE;
			timeout_q <= `RST_TIMEOUT;
			wants_q   <= 1'b0;
		end else if (wr_en) begin
			case (reg_addr)
				`OFF_MASTER:    master_q  <= reg_wdata;
				`OFF_SLAVE:     slave_q   <= reg_wdata;
				`OFF_TIMEOUT:   timeout_q <= {1'b0, reg_wdata[6:0]};
				`OFF_REQUESTER: wants_q   <= reg_wdata[`BIT_WANTS_BUS];
				default:        ;
			endcase
		end
	end

	// read data, one cycle after the strobe, zero otherwise
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rdata_q <= 8'h00;
		else if (reg_rd) begin
			case (reg_addr)
				`OFF_MASTER:     rdata_q <= master_q;
				`OFF_SLAVE:      rdata_q <= slave_q;
				`OFF_TIMEOUT:    rdata_q <= timeout_q;
				`OFF_REQUESTER:  rdata_q <= {wants_q, bus_held, 6'h00};
				`OFF_ERR_STATUS: rdata_q <= {7'h00, lto_flag_q};
				default:         rdata_q <= 8'h00;
			endcase
		end else
			rdata_q <= 8'h00;
	end
	assign reg_rdata = rdata_q;

	// requester and slave configuration outputs
	assign wants_bus     = wants_q;
	assign slave_enable  = slave_q[`BIT_SLV_EN];
	assign slave_narrow  = slave_q[`BIT_SLV_NARROW];
	assign slave_posting = slave_q[`BIT_SLV_POST];

	// local bus timer: runs on strobe, stops on select or iack
	assign lt_lim = short_lim(timeout_q[1:0]);
	assign lt_run = ds && !vsel && !iack &&
		(timeout_q[1:0] != 2'b11);
	assign lt_exp = lt_run && ({7'h00, lcnt_q} == lt_lim - 20'd1);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lcnt_q    <= '0;
			lto_err_q <= 1'b0;
		end else if (!lt_run) begin
			lcnt_q    <= '0;
			lto_err_q <= lto_err_q && ds;
		end else if (lt_exp)
			lto_err_q <= 1'b1;
		else if (!lto_err_q)
			lcnt_q <= lcnt_q + 13'd1;
	end

	// local timeout flag, a new timeout wins over a clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			lto_flag_q <= 1'b0;
		else if (lt_exp)
			lto_flag_q <= 1'b1;
		else if (wr_en && reg_addr == `OFF_ERR_STATUS &&
			reg_wdata[`BIT_LOCAL_TO])
			lto_flag_q <= 1'b0;
	end

	// access timer: runs while waiting for mastership, stopped while strobes run
	always_comb begin
		case (timeout_q[3:2])
			2'b00:   at_lim = `T_1K;
			2'b01:   at_lim = ACC_MID_CYC;
			default: at_lim = ACC_LONG_CYC;
		endcase
	end
	assign at_run = ds && (vsel || iack) &&
		st_q != vme_bridge_pkg::M_STROBE &&
		st_q != vme_bridge_pkg::M_ACK_DLY &&
		st_q != vme_bridge_pkg::M_ACK &&
		(timeout_q[3:2] != 2'b11);
	assign at_exp = at_run && (acnt_q == at_lim - 20'd1);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			acnt_q    <= '0;
			ato_err_q <= 1'b0;
		end else if (!at_run) begin
			acnt_q    <= '0;
			ato_err_q <= ato_err_q && ds;
		end else if (at_exp)
			ato_err_q <= 1'b1;
		else if (!ato_err_q)
			acnt_q <= acnt_q + 20'd1;
	end

	// VMEbus bus timer, only as system controller
	assign bt_lim = short_lim(timeout_q[5:4]);
	assign bt_run = syscon && vds && (timeout_q[5:4] != 2'b11);
	assign bt_exp = bt_run && ({7'h00, bcnt_q} == bt_lim - 20'd1);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bcnt_q  <= '0;
			vberr_q <= 1'b0;
		end else if (!bt_run) begin
			bcnt_q  <= '0;
			vberr_q <= 1'b0;
		end else if (bt_exp)
			vberr_q <= 1'b1;
		else if (!vberr_q)
			bcnt_q <= bcnt_q + 13'd1;
	end
	assign berr_out_n = ~vberr_q;

	// arbitration timer: grant without busy for 4096 clocks
	assign arb_exp = (arb_q == `ARB_WAIT_CYC - 13'd1);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			arb_q      <= '0;
			hold_q     <= '0;
			bbsy_drv_q <= 1'b0;
		end else if (bbsy_drv_q) begin
			arb_q <= '0;
			if (hold_q == 2'(`ARB_HOLD_CYC - 1))
				bbsy_drv_q <= 1'b0;
			else
				hold_q <= hold_q + 2'd1;
		end else if (syscon && timeout_q[`BIT_ARB_EN] && bg && !bbsy)
		begin
			if (arb_exp) begin
				bbsy_drv_q <= 1'b1;
				hold_q     <= '0;
			end else
				arb_q <= arb_q + 13'd1;
		end else
			arb_q <= '0;
	end
	assign bbsy_out_n = ~bbsy_drv_q;

	// address modifier computed from selects and function codes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			am_q   <= 6'h00;
			quad_q <= 1'b0;
		end else begin
			if (master_q[`BIT_SHORT_ADDR] || shrt)
				am_q[5:3] <= `AM_SHORT;
			else if (master_q[`BIT_STD_ADDR] || std24)
				am_q[5:3] <= `AM_STD;
			else
				am_q[5:3] <= `AM_EXT;
			am_q[2:0] <= fcs;
			quad_q <= master_q[`BIT_CACHE_FILL] && !wr && quad;
		end
	end
	assign am_out        = am_q;
	assign quad_read_out = quad_q;

	// master cycle sequencer with posting, lockup abort, ack delay
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q  <= vme_bridge_pkg::M_IDLE;
			dly_q <= '0;
			perr_q <= 1'b0;
		end else begin
			perr_q <= 1'b0;
			case (st_q)
				vme_bridge_pkg::M_IDLE:
					if (ds && vsel)
						st_q <= vme_bridge_pkg::M_WAIT_BUS;
				vme_bridge_pkg::M_WAIT_BUS:
					if (!ds)
						st_q <= vme_bridge_pkg::M_IDLE;
					else if (slave_busy && !bus_held)
						st_q <= vme_bridge_pkg::M_ABORT;
					else if (master_q[`BIT_MST_POST] && wr &&
						(!slave_q[`BIT_SLV_EN] || bus_held))
						st_q <= vme_bridge_pkg::M_ACK;
					else if (bus_held)
						st_q <= vme_bridge_pkg::M_STROBE;
				vme_bridge_pkg::M_STROBE:
					if (dtack || berr) begin
						dly_q <= '0;
						st_q  <= master_q[`BIT_DELAY_ACK] ?
							vme_bridge_pkg::M_ACK_DLY :
							vme_bridge_pkg::M_ACK;
					end
				vme_bridge_pkg::M_ACK_DLY:
					if (dly_q == `ACK_DELAY_CYC - 2'd1)
						st_q <= vme_bridge_pkg::M_ACK;
					else
						dly_q <= dly_q + 2'd1;
				vme_bridge_pkg::M_ACK:
					if (!ds)
						st_q <= (master_q[`BIT_MST_POST] && wr &&
							!vds && !dtack) ?
							vme_bridge_pkg::M_POST :
							vme_bridge_pkg::M_IDLE;
				vme_bridge_pkg::M_POST:
					if (bus_held && (dtack || berr)) begin
						perr_q <= berr;
						st_q   <= vme_bridge_pkg::M_IDLE;
					end
				vme_bridge_pkg::M_ABORT:
					if (!ds)
						st_q <= vme_bridge_pkg::M_IDLE;
				default:
					st_q <= vme_bridge_pkg::M_IDLE;
			endcase
		end
	end
	assign posted_error = perr_q;
	assign vme_strobe_out = (st_q == vme_bridge_pkg::M_STROBE) ||
		(st_q == vme_bridge_pkg::M_POST && bus_held);

	// registered local acknowledge, bus error and halt
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			local_berr_q <= 1'b0;
			halt_q       <= 1'b0;
			ack_q        <= 2'b00;
		end else begin
			local_berr_q <= lto_err_q || ato_err_q ||
				st_q == vme_bridge_pkg::M_ABORT ||
				(st_q == vme_bridge_pkg::M_ACK && berr &&
				!master_q[`BIT_MST_POST]);
			halt_q <= st_q == vme_bridge_pkg::M_ABORT &&
				!master_q[`BIT_OLDER_CPU];
			ack_q <= (st_q == vme_bridge_pkg::M_ACK && ds && !berr)
				? 2'b11 : 2'b00;
		end
	end
	assign local_bus_error_out_n = ~local_berr_q;
	assign local_halt_out_n      = ~halt_q;
	assign local_data_ack_out_n  = ~ack_q;

endmodule // vme_bridge_config_and_timeouts

// file: sim/vme_bridge_props.sv
/* concurrent checks on the bridge configuration and timeout block
   assumes: bound into the top module, one clock domain */
`timescale 1ns/1ns
module vme_bridge_props (
	// clock and reset
	input wire logic       clk,
	input wire logic       resetn,
	// watched ports
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [2:0] fc,
	input wire logic       short_io_select_in_n,
	input wire logic       local_data_strobe_n,
	input wire logic       system_controller_select_in_n,
	input wire logic [1:0] vme_ds_in_n,
	input wire logic       bus_held,
	input wire logic       local_bus_error_out_n,
	input wire logic       local_halt_out_n,
	input wire logic [1:0] local_data_ack_out_n,
	input wire logic [5:0] am_out,
	input wire logic       vme_strobe_out,
	input wire logic       berr_out_n,
	input wire logic       bbsy_out_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// bbsy drive: three cycles low, then released
	sequence bbsy_pulse;
		!bbsy_out_n[*3] ##1 bbsy_out_n;
	endsequence
	// short select held long enough to reach the modifier output
	sequence short_held;
		!short_io_select_in_n[*5];
	endsequence
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	chk_am_short: assert property (short_held |-> am_out[5:3] == 3'b101)
		else $error("short select gave wrong modifier");
	chk_am_fc_copy: assert property ($stable(fc)[*5] |-> am_out[2:0] == fc)
		else $error("modifier low bits differ from fc");
	chk_halt_with_berr: assert property (!local_halt_out_n |-> !local_bus_error_out_n)
		else $error("halt without bus error");
	chk_ds_release: assert property (
		local_data_strobe_n[*5] |->
		local_bus_error_out_n && local_data_ack_out_n == 2'b11)
		else $error("local outputs held after strobe released");
	chk_vme_berr_drop: assert property ((&vme_ds_in_n)[*4] |-> berr_out_n)
		else $error("bus error held with strobes released");
	chk_no_syscon: assert property (system_controller_select_in_n[*8]
		|-> berr_out_n && bbsy_out_n)
		else $error("system timers active without syscon");
	chk_bbsy_shape: assert property ($fell(bbsy_out_n) |-> bbsy_pulse)
		else $error("bbsy drive not three cycles");
	chk_strobe_mastered: assert property (
		$rose(vme_strobe_out) |-> bus_held)
		else $error("strobes without mastership");
endmodule // vme_bridge_props

bind vme_bridge_config_and_timeouts vme_bridge_props u_vme_bridge_props (
	.clk, .resetn, .reg_rd, .reg_rdata, .fc, .short_io_select_in_n,
	.local_data_strobe_n, .system_controller_select_in_n, .vme_ds_in_n,
	.bus_held, .local_bus_error_out_n, .local_halt_out_n,
	.local_data_ack_out_n, .am_out, .vme_strobe_out, .berr_out_n, .bbsy_out_n
);

// file: sim/vme_far_side.sv
/* far side stand-in: bus mastership path and a VMEbus slave
   assumes: same clock as the bridge, strobes come from the bridge */
`timescale 1ns/1ns
module vme_far_side (
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// bridge side
	input  wire logic wants_bus,
	input  wire logic vme_strobe_out,
	// scenario controls
	input  wire logic fail,
	input  wire logic slow,
	// answers
	output logic      bus_held,
	output logic      dtack_n,
	output logic      berr_in_n
);
	logic [3:0] grant_q;
	logic [2:0] wait_q;
	// mastership follows the request four cycles late
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) grant_q <= 4'h0;
		else grant_q <= {grant_q[2:0], wants_bus};
	end
	assign bus_held = grant_q[3];
	// slave answers after three or seven strobe cycles; idle lines pull up
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) wait_q <= 3'h0;
		else if (!vme_strobe_out) wait_q <= 3'h0;
		else if (wait_q != 3'h7) wait_q <= wait_q + 3'h1;
	end
	assign dtack_n = !(wait_q >= (slow ? 3'h7 : 3'h3) && !fail);
	assign berr_in_n = !(wait_q >= (slow ? 3'h7 : 3'h3) && fail);
endmodule // vme_far_side

// file: sim/tb_vme_bridge_config_and_timeouts.sv
/* self-checking bench for the configuration and timeout block
   assumes: far side model and checker compiled alongside */
`timescale 1ns/1ns
`include "vme_bridge_consts.svh"
module tb_vme_bridge_config_and_timeouts;
	logic clk, resetn, reg_wr, reg_rd, local_write, fail, slow, slave_busy;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic local_data_strobe_n, vme_window_select_in_n, short_io_select_in_n;
	logic standard_address_select_in_n, system_controller_select_in_n;
	logic local_bus_error_out_n, local_halt_out_n, dtack_n, berr_in_n;
	logic bus_grant_n, vme_strobe_out, berr_out_n, bbsy_out_n, bus_held;
	logic wants_bus, posted_error, slave_enable, slave_narrow, slave_posting;
	logic [1:0] local_data_ack_out_n, vme_ds_in_n;
	logic [2:0] fc;
	logic [5:0] am_out;
	logic local_int_ack_in_n, bbsy_in_n, quad_capable, quad_read_out;
	int failures, checks_done, n, t0, m[2];
	int cyc = 0;
	int perr_seen = 0;
	int lim_t[3] = '{1024, 2048, 4096};
	int lim_a[3] = '{1024, 64, 128};
	// {master setup, short pin, standard pin, expected upper modifier}
	logic [12:0] am_tab[5] = '{13'h09d, 13'h00d, 13'h05f, 13'h017,
		13'h019};

	vme_bridge_config_and_timeouts #(.ACC_MID_CYC(20'd64),
		.ACC_LONG_CYC(20'd128)) u_vme_bridge_config_and_timeouts (
		.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.local_data_strobe_n, .local_write, .fc, .vme_window_select_in_n,
		.local_int_ack_in_n, .short_io_select_in_n,
		.standard_address_select_in_n, .system_controller_select_in_n,
		.local_bus_error_out_n, .local_halt_out_n, .local_data_ack_out_n,
		.dtack_n, .berr_in_n, .vme_ds_in_n, .bus_grant_n, .bbsy_in_n,
		.quad_capable, .am_out, .vme_strobe_out, .quad_read_out,
		.berr_out_n, .bbsy_out_n, .bus_held, .slave_busy, .wants_bus,
		.posted_error, .slave_enable, .slave_narrow, .slave_posting);
	vme_far_side u_vme_far_side (.clk, .resetn, .wants_bus, .vme_strobe_out,
		.fail, .slow, .bus_held, .dtack_n, .berr_in_n);

	// clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// cycle count, posted error pulses, hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (posted_error === 1'b1) perr_seen <= perr_seen + 1;
		if (cyc == 60000) begin
			failures++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// count cycles until the chosen active-low output falls
	task automatic timed(input int lim, w);
		n = 0;
		while ((w == 0 ? local_bus_error_out_n : w == 1 ? berr_out_n
			: bbsy_out_n) !== 1'b0) begin
			@(posedge clk);
			n++;
		end
		check(n >= lim - 2 && n <= lim + 8, 1'b1);
	endtask
	// start a local cycle through the VMEbus window
	task automatic go(input logic wr_cyc);
		local_write <= wr_cyc;
		vme_window_select_in_n <= 1'b0;
		local_data_strobe_n <= 1'b0;
	endtask
	task automatic stop();
		local_data_strobe_n <= 1'b1;
		vme_window_select_in_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask

	// main sequence
	initial begin
		{resetn, reg_wr, reg_rd, local_write, fail, slow, slave_busy} = '0;
		{reg_addr, reg_wdata, fc, vme_ds_in_n} = {19'h0, 2'b11};
		{local_data_strobe_n, vme_window_select_in_n, bus_grant_n} = 3'h7;
		{short_io_select_in_n, standard_address_select_in_n} = 2'b11;
		{local_int_ack_in_n, bbsy_in_n, quad_capable} = 3'b110;
		system_controller_select_in_n = 1'b1;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		rd(8'h07);
		check(d, 8'h00);
		wr(8'h09, 8'hff);
		rd(8'h09);
		check(d, 8'h7f);
		wr(8'h0b, 8'hff);
		rd(8'h0b);
		check(d, 8'h00);
		// modifier table over short, standard and extended selections
		fc <= 3'h5;
		for (int k = 0; k < 5; k++) begin
			wr(`OFF_MASTER, am_tab[k][12:5]);
			short_io_select_in_n <= am_tab[k][4];
			standard_address_select_in_n <= am_tab[k][3];
			repeat (5) @(posedge clk);
			check(am_out, {am_tab[k][2:0], 3'h5});
		end
		{short_io_select_in_n, standard_address_select_in_n} <= 2'b11;
		// cache fill asks for a quad read only from capable memory
		wr(`OFF_MASTER, 8'h10);
		quad_capable <= 1'b1;
		repeat (5) @(posedge clk);
		check(quad_read_out, 1'b1);
		quad_capable <= 1'b0;
		repeat (5) @(posedge clk);
		check(quad_read_out, 1'b0);
		// posted write with slave off acks early; its error gives a posted error pulse, not local berr
		wr(8'h09, 8'h3f);
		wr(`OFF_MASTER, 8'h20);
		fail <= 1'b1;
		go(1'b1);
		while (local_data_ack_out_n !== 2'b00) @(posedge clk);
		check(bus_held, 1'b0);
		stop();
		wr(`OFF_REQUESTER, 8'h80);
		repeat (20) @(posedge clk);
		check({perr_seen[1:0], local_bus_error_out_n}, 3'b011);
		fail <= 1'b0;
		// slave setup changed only while holding the bus
		d = 8'h00;
		while (!d[6]) rd(`OFF_REQUESTER);
		wr(`OFF_SLAVE, 8'ha1);
		@(posedge clk);
		check({slave_enable, slave_posting, slave_narrow}, 3'h7);
		check(wants_bus, 1'b1);
		wr(`OFF_REQUESTER, 8'h00);
		repeat (6) @(posedge clk);
		// posted write with slave on waits for mastership, slow slave
		slow <= 1'b1;
		go(1'b1);
		repeat (20) @(posedge clk);
		check(local_data_ack_out_n, 2'b11);
		wr(`OFF_REQUESTER, 8'h80);
		while (local_data_ack_out_n !== 2'b00) @(posedge clk);
		check({bus_held, vme_strobe_out}, 2'b10);
		stop();
		slow <= 1'b0;
		// plain and delayed acknowledge of a read
		for (int k = 0; k < 2; k++) begin
			wr(`OFF_MASTER, {k[0], 7'h00});
			t0 = cyc;
			go(1'b0);
			while (local_data_ack_out_n !== 2'b00) @(posedge clk);
			m[k] = cyc - t0;
			stop();
		end
		check(m[1] - m[0], 2);
		// lockup break with and without halt
		wr(`OFF_REQUESTER, 8'h00);
		slave_busy <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			wr(`OFF_MASTER, {1'b0, k[0], 6'h00});
			go(1'b0);
			repeat (10) @(posedge clk);
			check({local_bus_error_out_n, local_halt_out_n}, k[0]);
			stop();
		end
		slave_busy <= 1'b0;
		wr(`OFF_MASTER, 8'h00);
		// local timer codes; window and iack left alone meanwhile
		for (int k = 0; k < 4; k++) begin
			wr(`OFF_TIMEOUT, {6'h0f, k[1:0]});
			local_data_strobe_n <= 1'b0;
			if (k < 3) timed(lim_t[k], 0);
			else repeat (4200) @(posedge clk);
			check(local_bus_error_out_n, k == 3);
			stop();
			rd(`OFF_ERR_STATUS);
			check(d, {7'h0, k < 3});
			wr(`OFF_ERR_STATUS, 8'h01);
		end
		// an interrupt acknowledge keeps the local timer stopped
		wr(`OFF_TIMEOUT, 8'h3c);
		local_int_ack_in_n <= 1'b0;
		local_data_strobe_n <= 1'b0;
		repeat (1100) @(posedge clk);
		check(local_bus_error_out_n, 1'b1);
		local_int_ack_in_n <= 1'b1;
		stop();
		// access timer codes with shortened long counts
		for (int k = 0; k < 3; k++) begin
			wr(`OFF_TIMEOUT, {4'h3, k[1:0], 2'b11});
			go(1'b0);
			timed(lim_a[k], 0);
			stop();
		end
		// bus timer needs syscon
		wr(`OFF_TIMEOUT, 8'h0f);
		vme_ds_in_n <= 2'b10;
		repeat (4200) @(posedge clk);
		check(berr_out_n, 1'b1);
		vme_ds_in_n <= 2'b11;
		system_controller_select_in_n <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			wr(`OFF_TIMEOUT, {2'b00, k[1:0], 4'hf});
			vme_ds_in_n <= 2'b01;
			timed(lim_t[k], 1);
			vme_ds_in_n <= 2'b11;
			repeat (8) @(posedge clk);
		end
		// arbitration timer after an unclaimed grant
		wr(`OFF_TIMEOUT, 8'h7f);
		bus_grant_n <= 1'b0;
		timed(4096, 2);
		bus_grant_n <= 1'b1;
		repeat (10) @(posedge clk);
		// a grant that is claimed leaves busy undriven
		bbsy_in_n <= 1'b0;
		bus_grant_n <= 1'b0;
		repeat (4200) @(posedge clk);
		check(bbsy_out_n, 1'b1);
		bus_grant_n <= 1'b1;
		bbsy_in_n <= 1'b1;
		repeat (10) @(posedge clk);
		stop_test();
	end
endmodule // tb_vme_bridge_config_and_timeouts
